// File: rtl/cxs_output_two_regs.sv
`timescale 1ns/10ps
`default_nettype none
module cxs_output_two_regs #(
  parameter int NUM_MUX = cxs_pkg::CXS_NUM_MUX
) (
  // Clock, reset, enable
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 clk_en,
  // APB slave
  input  wire cxs_pkg::cxs_apb_req_t apb_req,
  output var cxs_pkg::cxs_apb_rsp_t apb_rsp,
  // Crossbar candidates, four per multiplexer
  input  wire logic [4*NUM_MUX-1:0] cand_in,
  // Multiplexer results and current selects
  output logic [NUM_MUX-1:0]        mux_out,
  output logic [2*NUM_MUX-1:0]      sel_out
);
  import cxs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  // Byte lanes merged into a word
  function automatic logic [31:0] cxs_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    // Start from the held word
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : cxs_merge

  logic        acc;          // Access phase
  logic        hit_low;      // Low register hit
  logic        hit_high;     // High register hit
  logic [31:0] sel_low_q;    // Selects 0..15
  logic [31:0] sel_high_q;   // Selects 16..31
  logic [31:0] prdata_q;     // Registered read data
  logic        pslverr_q;    // Registered error
  logic        rd_done_q;    // Read answer ready

  // Access phase and the two address hits
  assign acc      = apb_req.psel & apb_req.penable;
  assign hit_low  = apb_req.paddr == CXS_ADDR_SEL_LOW;
  assign hit_high = apb_req.paddr == CXS_ADDR_SEL_HIGH;

  ////////////////////////////////////////////////////////////////////////////
  // Select registers

  // Writes land at the access edge; only sys_rst clears them
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // Reset acts even with the enable low
      sel_low_q  <= CXS_SEL_RESET;
      sel_high_q <= CXS_SEL_RESET;
    end else if (clk_en && acc && apb_req.pwrite) begin
      // Low register
      if (hit_low) begin
        sel_low_q <= cxs_merge(sel_low_q, apb_req.pwdata,
                               apb_req.pstrb);
      end
      // High register
      if (hit_high) begin
        sel_high_q <= cxs_merge(sel_high_q, apb_req.pwdata,
                                apb_req.pstrb);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path and answer

  // Reads take one wait cycle; data from flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_q  <= CXS_RDATA_NONE;
      pslverr_q <= 1'b0;
      rd_done_q <= 1'b0;
    end else if (clk_en) begin
      if (acc && !rd_done_q) begin
        // Capture data and error
        rd_done_q <= !apb_req.pwrite;
        pslverr_q <= !(hit_low || hit_high);
        // Pick the word to return
        if (apb_req.pwrite) begin
          // Writes carry no data back
          prdata_q <= CXS_RDATA_NONE;
        end else if (hit_low) begin
          prdata_q <= sel_low_q;
        end else if (hit_high) begin
          prdata_q <= sel_high_q;
        end else begin
          // Unmapped read returns zero
          prdata_q <= CXS_RDATA_NONE;
        end
      end else begin
        // Answer given or bus idle
        rd_done_q <= 1'b0;
      end
    end
  end

  // Writes answer at once, reads one cycle later
  // A low enable stalls both, so no write is acknowledged unlanded
  always_comb begin
    apb_rsp.pready  = acc & clk_en & (apb_req.pwrite | rd_done_q);
    // Error shows only with the ready that carries it
    if (apb_req.pwrite) begin
      apb_rsp.pslverr = apb_rsp.pready & !(hit_low | hit_high);
    end else begin
      apb_rsp.pslverr = apb_rsp.pready & pslverr_q;
    end
    apb_rsp.prdata  = prdata_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Routing

  // Flat select vector, mux n at bits 2n+1:2n
  assign sel_out = {sel_high_q, sel_low_q};

  // One multiplexer per source
  for (genvar n = 0; n < NUM_MUX; n++) begin : g_mux
    cxs_sel_mux u_mux (
      .cand_in  (cand_in[4*n +: 4]),
      .sel      (sel_out[2*n +: 2]),
      .pick_out (mux_out[n])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Full-word writes, the cases the write checks cover
  logic wr_low;
  logic wr_high;
  assign wr_low  = clk_en & acc & apb_req.pwrite & hit_low
                   & (apb_req.pstrb == 4'hF);
  assign wr_high = clk_en & acc & apb_req.pwrite & hit_high
                   & (apb_req.pstrb == 4'hF);

  // A full low write lands whole
  low_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_low |=> sel_low_q == $past(apb_req.pwdata))
    else $error("low select write lost");

  // A full high write lands whole
  high_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_high |=> sel_high_q == $past(apb_req.pwdata))
    else $error("high select write lost");

  // Top multiplexer follows its select code
  mux_pick_a: assert property (@(posedge clk) disable iff (sys_rst)
    mux_out[31] == cand_in[4*31 + sel_high_q[31:30]])
    else $error("mux 31 picks wrong candidate");

  // Mux 16 uses high bits 1:0, mux 15 low bits 31:30
  field_map_a: assert property (@(posedge clk) disable iff (sys_rst)
    mux_out[16] == cand_in[4*16 + sel_high_q[1:0]] &&
    mux_out[15] == cand_in[4*15 + sel_low_q[31:30]])
    else $error("select field map wrong");

  // Reset clears both registers
  reset_zero_a: assert property (@(posedge clk)
    sys_rst |=> sel_low_q == 32'h0000_0000 && sel_high_q == 32'h0000_0000)
    else $error("selects not cleared by reset");

  // Low register reads back what it holds
  read_back_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && acc && !apb_req.pwrite && hit_low && !rd_done_q
    |=> prdata_q == $past(sel_low_q))
    else $error("read data mismatch");

  // High register reads back what it holds
  high_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && acc && !apb_req.pwrite && hit_high && !rd_done_q
    |=> prdata_q == $past(sel_high_q))
    else $error("high read data mismatch");

  // A read waits one cycle for its data
  read_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && acc && !apb_req.pwrite && !rd_done_q |-> !apb_rsp.pready)
    else $error("read answered without wait");

  // Routing takes the new select one cycle on
  route_next_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_low |=> sel_out[1:0] == $past(apb_req.pwdata[1:0]))
    else $error("routing not updated next cycle");

  // Nothing is acknowledged while frozen
  bus_stall_a: assert property (@(posedge clk) disable iff (sys_rst)
    !clk_en |-> !apb_rsp.pready)
    else $error("bus answered while frozen");

  // Unmapped writes leave both registers alone
  bad_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && acc && apb_req.pwrite && !hit_low && !hit_high
    |=> $stable(sel_low_q) && $stable(sel_high_q))
    else $error("unmapped write changed a select");

  // Enable low freezes the selects
  hold_sel_a: assert property (@(posedge clk) disable iff (sys_rst)
    !clk_en |=> $stable(sel_low_q) && $stable(sel_high_q))
    else $error("selects moved while frozen");

  // Main scenarios to be reached
  cov_stall: cover property (@(posedge clk) acc && !clk_en);
  cov_wr_low: cover property (@(posedge clk) wr_low);
  cov_wr_high: cover property (@(posedge clk) wr_high);
  cov_rd: cover property (@(posedge clk) apb_rsp.pready && !apb_req.pwrite);
  cov_err: cover property (@(posedge clk) apb_rsp.pready && apb_rsp.pslverr);

endmodule : cxs_output_two_regs
`default_nettype wire

// File: inc/cxs_pkg.sv
`default_nettype none
package cxs_pkg;

  // Register indices; byte address is four times the index
  localparam logic [3:0]  CXS_IDX_SEL_LOW   = 4'h4;
  localparam logic [3:0]  CXS_IDX_SEL_HIGH  = 4'h6;
  localparam logic [11:0] CXS_ADDR_SEL_LOW  = {6'h00, CXS_IDX_SEL_LOW, 2'h0};
  localparam logic [11:0] CXS_ADDR_SEL_HIGH = {6'h00, CXS_IDX_SEL_HIGH, 2'h0};

  // Field layout
  localparam int          CXS_FIELD_W   = 2;
  localparam int          CXS_NUM_MUX   = 32;
  localparam int          CXS_PER_REG   = 16;
  localparam logic [31:0] CXS_SEL_RESET = 32'h0000_0000;
  localparam logic [31:0] CXS_RDATA_NONE = 32'h0000_0000;

  // Address width of the register port
  localparam int          CXS_AW = 12;

  // APB request carrier
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [CXS_AW-1:0] paddr;
    logic [31:0]       pwdata;
    logic [3:0]        pstrb;
  } cxs_apb_req_t;

  // APB answer carrier
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } cxs_apb_rsp_t;

endpackage : cxs_pkg
`default_nettype wire

// File: rtl/cxs_sel_mux.sv
`timescale 1ns/10ps
`default_nettype none
// One source multiplexer: picks one of four candidate inputs
module cxs_sel_mux (
  // Candidates and select
  input  wire logic [3:0] cand_in,
  input  wire logic [1:0] sel,
  // Picked value
  output logic            pick_out
);
  import cxs_pkg::*;

  // Select code is the candidate number directly
  always_comb begin
    pick_out = cand_in[sel];
  end

endmodule : cxs_sel_mux
`default_nettype wire

// File: test/cxs_output_two_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module cxs_output_two_regs_tb_top;
  import cxs_pkg::*;
  logic         clk = 1'b0;   // 200 MHz clock
  logic         sys_rst = 1'b1; // Synchronous reset
  logic         clk_en = 1'b1;  // Global enable
  cxs_apb_req_t req = '0;       // Bus request
  cxs_apb_rsp_t rsp;            // Bus answer
  logic [127:0] cand = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  logic [31:0]  mux_out;        // Picked values
  logic [63:0]  sel_out;        // Current selects
  logic [31:0]  lo = '0;        // Expected low register
  logic [31:0]  hi = '0;        // Expected high register
  logic [31:0]  r;              // Read data
  logic         e;              // Error answer
  logic [3:0]   strb = 4'hF;    // Byte strobes of the next transfer
  int           mismatches = 0;
  int           cmp_count = 0;
  // Ordinary cases: address, write data, read back, error
  logic [11:0]  ra[4] = '{CXS_ADDR_SEL_LOW, CXS_ADDR_SEL_HIGH, 12'h014,
                          CXS_ADDR_SEL_LOW};
  logic [31:0]  rd[4] = '{32'hE4E4_E4E4, 32'h1B1B_1B1B, 32'hFFFF_FFFF,
                          32'hFFFF_FFFF};
  logic [31:0]  rx[4] = '{32'hE4E4_E4E4, 32'h1B1B_1B1B, 32'h0000_0000,
                          32'hFFFF_FFFF};
  logic         re[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
  always #2.5 clk = ~clk;
  cxs_output_two_regs dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .apb_req(req), .apb_rsp(rsp), .cand_in(cand), .mux_out(mux_out),
    .sel_out(sel_out));
  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic summarize();
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // Value compare
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int   i;
    logic rdy;
    @(posedge clk);
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    req.pstrb <= strb;
    @(posedge clk);
    req.penable <= 1'b1;
    // Note the answer mid-cycle, act at the edge that samples it
    for (i = 0; i < 20; i++) begin
      @(negedge clk);
      rdy = rsp.pready;
      r = rsp.prdata;
      e = rsp.pslverr;
      @(posedge clk);
      if (rdy === 1'b1) break;
    end
    if (i == 20) begin
      mismatches++;
      summarize();
    end
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  // Selects and mux picks against the expected registers
  task automatic chk_out();
    logic [31:0] x;
    logic [63:0] s;
    @(negedge clk);
    s = {hi, lo};
    chk(sel_out, s);
    for (int n = 0; n < 32; n++) x[n] = cand[4*n + s[2*n +: 2]];
    chk({32'h0000_0000, mux_out}, {32'h0000_0000, x});
  endtask : chk_out
  // Read both registers and compare
  task automatic rd_both();
    apb(1'b0, CXS_ADDR_SEL_LOW, 32'h0000_0000);
    chk({32'h0000_0000, r}, {32'h0000_0000, lo});
    chk({63'h0, e}, 64'h0);
    apb(1'b0, CXS_ADDR_SEL_HIGH, 32'h0000_0000);
    chk({32'h0000_0000, r}, {32'h0000_0000, hi});
    chk({63'h0, e}, 64'h0);
  endtask : rd_both
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd_both();
    chk_out();
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      cand <= {cand[126:0], cand[127]};
      apb(1'b1, ra[k], rd[k]);
      chk({63'h0, e}, {63'h0, re[k]});
      if (ra[k] == CXS_ADDR_SEL_LOW) lo = rd[k];
      if (ra[k] == CXS_ADDR_SEL_HIGH) hi = rd[k];
      chk_out();
      apb(1'b0, ra[k], 32'h0000_0000);
      chk({32'h0000_0000, r}, {32'h0000_0000, rx[k]});
      chk({63'h0, e}, {63'h0, re[k]});
    end
    // Byte strobes merge only the enabled lane
    strb = 4'h2;
    apb(1'b1, CXS_ADDR_SEL_HIGH, 32'hC6C6_C6C6);
    strb = 4'hF;
    hi[15:8] = 8'hC6;
    chk_out();
    // Enable low freezes the selects and stalls a pending write
    @(posedge clk);
    clk_en <= 1'b0;
    req.psel <= 1'b1;
    req.pwrite <= 1'b1;
    req.paddr <= CXS_ADDR_SEL_LOW;
    req.pwdata <= 32'h3333_0000;
    req.pstrb <= 4'hF;
    @(posedge clk);
    req.penable <= 1'b1;
    repeat (3) @(posedge clk);
    chk_out();
    chk({63'h0, rsp.pready}, 64'h0);
    @(posedge clk);
    clk_en <= 1'b1;
    @(negedge clk);
    chk({63'h0, rsp.pready}, {63'h0, 1'b1});
    @(posedge clk);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    lo = 32'h3333_0000;
    chk_out();
    // Reset in mid-run clears every field
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    lo = '0;
    hi = '0;
    chk_out();
    rd_both();
    summarize();
  end
endmodule : cxs_output_two_regs_tb_top
`default_nettype wire
